// >>> src/vcr_capture.sv
`timescale 1ns/10ps
// Functional notes
// - restart in non-mux mode with processing in path stalls the list
// - hang in both sync modes; discrete sync hangs on restart once the mux is switched, not on first run
// - list stalls to end of frame, mux switched in blanking
// - active-video qualifier delimits the region written to memory
// - vertical blanking lines never written even with qualifier high
module vcr_capture (
    input wire logic clk,
    input wire logic rst_n,
    input wire vcr_pkg::vcr_pix_t pixIn,
    input wire logic portEnable,
    input wire logic portReset,
    input wire logic fifoReset,
    input wire logic discreteSync,
    input wire logic procEnable,
    input wire logic listPosted,
    input wire logic [vcr_pkg::LINE_W-1:0] vblankLines,
    output logic [vcr_pkg::PIX_W-1:0] outData,
    output logic outValid,
    input wire logic outReady,
    output logic [1:0] muxPath,
    output logic listStalled,
    output logic captureHung,
    output logic inOverflow
);
    import vcr_pkg::*;

    vcr_regs_t r;
    vcr_regs_t nxt;
    logic inWord;
    logic bufReady;
    logic bufValid;
    logic lineStart;
    logic frameEnd;

    // ------------------------------------------------------------
    // pin qualification
    // ------------------------------------------------------------
    assign lineStart = r.sy.s3.hsync & ~r.prevHsync;
    assign frameEnd = r.sy.s3.vsync & ~r.prevVsync;
    assign bufValid = (r.cnt != 2'h0);
    assign bufReady = (r.cnt != TWO2);
    assign outValid = bufValid;
    assign outData = r.outData;
    assign muxPath = r.path;
    assign listStalled = (r.st == VCR_WAIT_EOF);
    assign captureHung = r.hung;

    // qualifier from the last stage, held at its old value while the two stages disagree, and line is past blanking
    always_comb
    begin
        inWord = 1'b0;
        if (r.st == VCR_RUN && portEnable && !portReset && !fifoReset)
        begin
            // a qualifier change counts once both stages agree
            inWord = (r.sy.s2.active_video_qualifier == r.sy.s3.active_video_qualifier) ? r.sy.s3.active_video_qualifier
                : r.prevActVid;
            if (r.lineCnt < vblankLines)
            begin
                inWord = 1'b0;
            end
        end
    end
    assign inOverflow = inWord & ~bufReady;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic pop;
        logic push;
        nxt = r;
        pop = bufValid & outReady;
        push = inWord & bufReady;
        nxt.sy.s1 = pixIn;
        nxt.sy.s2 = r.sy.s1;
        nxt.sy.s3 = r.sy.s2;
        nxt.prevVsync = r.sy.s3.vsync;
        nxt.prevHsync = r.sy.s3.hsync;
        nxt.prevActVid = r.sy.s3.active_video_qualifier;
        if (frameEnd)
        begin
            nxt.lineCnt = '0;
        end
        else if (lineStart && r.lineCnt != {LINE_W{1'b1}})
        begin
            nxt.lineCnt = r.lineCnt + 12'h001;
        end
        case (r.st)
            VCR_IDLE:
            begin
                if (portEnable && listPosted)
                begin
                    if (discreteSync && r.path == PATH_BYPASS)
                    begin
                        nxt.st = VCR_DROP;
                    end
                    else if (procEnable && (discreteSync || r.hung))
                    begin
                        nxt.st = VCR_WAIT_EOF;
                        nxt.hung = 1'b1;
                    end
                    else
                    begin
                        nxt.st = VCR_RUN;
                    end
                end
            end
            VCR_DROP:
            begin
                // discard descriptor: data dropped, no writeback
                nxt.st = VCR_WAIT_EOF;
            end
            VCR_WAIT_EOF:
            begin
                if (frameEnd && !r.hung)
                begin
                    nxt.st = VCR_APPLY;
                end
            end
            VCR_APPLY:
            begin
                if (procEnable)
                begin
                    nxt.path = PATH_PROC;
                end
                nxt.st = VCR_RUN;
            end
            VCR_RUN:
            begin
                if (!portEnable)
                begin
                    nxt.st = VCR_IDLE;
                    nxt.hung = r.hung
                        | (procEnable & ~discreteSync);
                end
            end
            default:
            begin
                nxt.st = VCR_IDLE;
            end
        endcase
        // recovery: port and FIFO reset together clear the hang; FIFO reset alone flushes the buffer
        if (portReset && fifoReset)
        begin
            nxt.st = VCR_IDLE;
            nxt.hung = 1'b0;
            nxt.path = PATH_BYPASS;
        end
        if (fifoReset)
        begin
            nxt.cnt = '0;
            nxt.rdPtr = 1'b0;
            nxt.wrPtr = 1'b0;
        end
        else
        begin
            // two-entry buffer
            if (push)
            begin
                if (r.wrPtr)
                begin
                    nxt.buf1 = r.sy.s3.data;
                end
                else
                begin
                    nxt.buf0 = r.sy.s3.data;
                end
                nxt.wrPtr = ~r.wrPtr;
            end
            if (pop)
            begin
                nxt.rdPtr = ~r.rdPtr;
            end
            if (push && !pop)
            begin
                nxt.cnt = r.cnt + ONE2;
            end
            else if (pop && !push)
            begin
                nxt.cnt = r.cnt - ONE2;
            end
        end
        // registered head of buffer
        if (nxt.cnt != 2'h0)
        begin
            nxt.outData = nxt.rdPtr ? nxt.buf1 : nxt.buf0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= nxt;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence stallSeq;
        r.st == VCR_WAIT_EOF && !frameEnd && !(portReset && fifoReset);
    endsequence

    sequence applySeq;
        r.st == VCR_APPLY ##1 r.st == VCR_RUN;
    endsequence

    no_blank_write_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (r.lineCnt < vblankLines && !fifoReset)
        |=> r.wrPtr == $past(r.wrPtr))
        else $error("blanking line accepted");

    qual_gate_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        inWord |-> (r.sy.s3.active_video_qualifier || r.prevActVid))
        else $error("word without qualifier");

    list_stall_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        stallSeq |=> r.path == $past(r.path))
        else $error("mux changed while stalled");

    apply_path_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (r.st == VCR_APPLY && procEnable && !(portReset && fifoReset))
        |=> muxPath == PATH_PROC)
        else $error("mux not switched");

    eof_apply_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (r.st == VCR_WAIT_EOF && frameEnd && !r.hung
         && !(portReset && fifoReset)) |=> applySeq)
        else $error("end of frame not applied");

    drop_step_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (r.st == VCR_DROP && !(portReset && fifoReset))
        |=> r.st == VCR_WAIT_EOF)
        else $error("discard step skipped");

    hang_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (r.hung && !(portReset && fifoReset)) |=> r.hung)
        else $error("hang cleared without resets");

    discrete_hang_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (r.st == VCR_IDLE && portEnable && listPosted && discreteSync
         && procEnable && r.path != PATH_BYPASS && !portReset)
        |=> captureHung)
        else $error("discrete hang missing");

    buf_bound_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        r.cnt <= TWO2)
        else $error("buffer count out of range");

endmodule

// >>> src/vcr_pkg.sv
package vcr_pkg;

    // ------------------------------------------------------------
    // widths and codes
    // ------------------------------------------------------------
    localparam int PIX_W = 24;
    localparam int LINE_W = 12;
    localparam logic [LINE_W-1:0] VBLANK_LINES_DEF = 12'h014;
    localparam logic [1:0] PATH_BYPASS = 2'h0;
    localparam logic [1:0] PATH_PROC = 2'h1;
    localparam logic [1:0] ONE2 = 2'h1;
    localparam logic [1:0] TWO2 = 2'h2;

    typedef enum logic [2:0] {
        VCR_IDLE = 3'b000,
        VCR_DROP = 3'b001,
        VCR_WAIT_EOF = 3'b010,
        VCR_APPLY = 3'b011,
        VCR_RUN = 3'b100
    } vcr_state_t;

    // incoming pixel with sync qualifiers
    typedef struct packed {
        logic [PIX_W-1:0] data;
        logic hsync;
        logic vsync;
        logic active_video_qualifier;
    } vcr_pix_t;

    // pin synchroniser state
    typedef struct packed {
        vcr_pix_t s1;
        vcr_pix_t s2;
        vcr_pix_t s3;
    } vcr_sync_t;

    typedef struct packed {
        vcr_sync_t sy;
        vcr_state_t st;
        logic [LINE_W-1:0] lineCnt;
        logic prevVsync;
        logic prevHsync;
        logic prevActVid;
        logic [1:0] path;
        logic [1:0] cnt;
        logic [PIX_W-1:0] buf0;
        logic [PIX_W-1:0] buf1;
        logic rdPtr;
        logic wrPtr;
        logic [PIX_W-1:0] outData;
        logic hung;
    } vcr_regs_t;

endpackage

// >>> tb/vcr_src.sv
`timescale 1ns/10ps
module vcr_src
    import vcr_pkg::*;
#(
    parameter int NL = 6,
    parameter int NP = 4
)
(
    input wire logic clk,
    input wire logic rst_n,
    output vcr_pix_t pixOut
);
    // ------------------------------------------------------------
    // free running frame timer
    // ------------------------------------------------------------
    localparam int LP = NP + 3;
    localparam int FR = 3 + NL * LP + 8;
    int t;
    int ln;
    int ph;
    logic inLine;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            t <= 0;
        else
            t <= (t == FR - 1) ? 0 : t + 1;
    end
    // ------------------------------------------------------------
    // sync pulses, qualifier and pixel data
    // ------------------------------------------------------------
    always_comb
    begin
        ln = (t - 3) / LP;
        ph = (t - 3) % LP;
        inLine = (t >= 3) && (ln < NL);
        pixOut.vsync = (t == 0);
        pixOut.hsync = inLine && (ph == 0);
        // qualifier high on every line, blanking lines too
        pixOut.active_video_qualifier = inLine && (ph >= 1) && (ph <= NP);
        if (pixOut.active_video_qualifier)
            pixOut.data = {12'(ln + 1), 12'(ph - 1)};
        else
            pixOut.data = 24'(~t);
    end
endmodule

// >>> tb/video_capture_restart_seq_tb.sv
`timescale 1ns/10ps
module video_capture_restart_seq_tb;
    import vcr_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int VB = 3;
    localparam int NL = 6;
    localparam int NP = 4;
    localparam int FR = 3 + NL * (NP + 3) + 8;
    logic clk, rst_n, portEnable, portReset, fifoReset, discreteSync;
    logic procEnable, listPosted, outReady, outValid, listStalled;
    logic captureHung, inOverflow, sawOvf;
    logic [PIX_W-1:0] outData;
    logic [1:0] muxPath;
    vcr_pix_t pix;
    int miscompares = 0;
    int cmp_count = 0;
    int n;
    logic [31:0] expw;
    vcr_src #(.NL(NL), .NP(NP)) src (.clk(clk), .rst_n(rst_n), .pixOut(pix));
    vcr_capture uut (.clk(clk), .rst_n(rst_n), .pixIn(pix),
        .portEnable(portEnable), .portReset(portReset),
        .fifoReset(fifoReset), .discreteSync(discreteSync),
        .procEnable(procEnable), .listPosted(listPosted),
        .vblankLines(12'h003), .outData(outData), .outValid(outValid),
        .outReady(outReady), .muxPath(muxPath), .listStalled(listStalled),
        .captureHung(captureHung), .inOverflow(inOverflow));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    function logic sel(input int k);
        case (k)
            0: return captureHung === 1'b1;
            1: return listStalled === 1'b1;
            2: return muxPath === PATH_PROC;
            default: return pix.vsync === 1'b1;
        endcase
    endfunction
    task wait_for(input int k);
        for (int i = 0; i < 300 && !sel(k); i++)
            @(negedge clk);
    endtask
    task restart();
        @(posedge clk);
        portEnable <= 1'b0;
        repeat (10) @(posedge clk);
        portEnable <= 1'b1;
        wait_for(0);
        repeat (FR) @(negedge clk);
    endtask
    task end_sim();
        if (miscompares == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_first_run();
        @(posedge clk);
        procEnable <= 1'b1;
        listPosted <= 1'b1;
        portEnable <= 1'b1;
        repeat (120) @(negedge clk);
        chk("hung first run", 0, captureHung);
        chk("stalled first run", 0, listStalled);
        restart();
        chk("hung restart", 1, captureHung);
        chk("stalled restart", 1, listStalled);
    endtask
    task t_recover();
        @(posedge clk);
        portEnable <= 1'b0;
        @(posedge clk);
        portReset <= 1'b1;
        @(posedge clk);
        fifoReset <= 1'b1;
        listPosted <= 1'b0;
        repeat (10) @(posedge clk);
        portReset <= 1'b0;
        @(posedge clk);
        fifoReset <= 1'b0;
        repeat (4) @(negedge clk);
        chk("hung recovered", 0, captureHung);
        chk("stall aborted", 0, listStalled);
        chk("valid flushed", 0, outValid);
    endtask
    task t_discrete();
        @(posedge clk);
        discreteSync <= 1'b1;
        listPosted <= 1'b1;
        portEnable <= 1'b1;
        wait_for(1);
        chk("stalled", 1, listStalled);
        chk("mux bypass", PATH_BYPASS, muxPath);
        wait_for(2);
        chk("mux proc", PATH_PROC, muxPath);
        chk("hung discrete", 0, captureHung);
    endtask
    task t_frame();
        wait_for(3);
        @(negedge clk);
        n = 0;
        repeat (FR - 2)
        begin
            @(negedge clk);
            if (outValid === 1'b1 && outReady === 1'b1)
            begin
                expw = {12'(VB + n / NP), 12'(n % NP)};
                chk("word", expw, outData);
                n++;
            end
        end
        chk("word count", (NL - VB + 1) * NP, n);
    endtask
    task t_stall();
        wait_for(3);
        @(posedge clk);
        outReady <= 1'b0;
        sawOvf = 1'b0;
        repeat (48)
        begin
            @(negedge clk);
            sawOvf = sawOvf | (inOverflow === 1'b1);
        end
        chk("overflow seen", 1, sawOvf);
        chk("valid held", 1, outValid);
        @(posedge clk);
        outReady <= 1'b1;
        @(negedge clk);
        chk("held word", {12'(VB), 12'h000}, outData);
        repeat (3) @(negedge clk);
        chk("drained", 0, outValid);
    endtask
    task t_discrete_restart();
        restart();
        chk("hung discrete restart", 1, captureHung);
        chk("stalled discrete restart", 1, listStalled);
    endtask
    // ------------------------------------------------------------
    // clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        {rst_n, portEnable, portReset, fifoReset} = 4'h0;
        {discreteSync, procEnable, listPosted} = 3'h0;
        outReady = 1'b1;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_first_run();
        t_recover();
        t_discrete();
        t_frame();
        t_stall();
        t_discrete_restart();
        end_sim();
    end
    initial
    begin
        #20000;
        miscompares++;
        end_sim();
    end
endmodule
